// ---- src/ots_signal_top.sv ----
// ots_signal_top: orientation lines, tap interrupt pin, power-down and register port
// assumes synchronous inputs and one sample enable per measurement from the chain
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
module ots_signal_top
  import ots_pkg::*;
#(
  parameter int unsigned TURN_ON_CYC_P = TURN_ON_CYC
)
(
  input  wire logic                 REF_CLK_I,
  input  wire logic                 SYS_RST_I,
  input  wire logic                 LOW_POWER_SELECT_I,
  input  wire logic                 SAMPLE_VALID_I,
  input  wire logic signed [SW-1:0] ACC_X_I,
  input  wire logic signed [SW-1:0] ACC_Y_I,
  input  wire logic signed [SW-1:0] ACC_Z_I,
  input  wire logic        [AW-1:0] REG_ADDR_I,
  input  wire logic        [DW-1:0] REG_WDATA_I,
  input  wire logic                 REG_WR_I,
  input  wire logic                 REG_RD_I,
  output logic             [DW-1:0] REG_RDATA_O,
  output logic                      PORTRAIT_INDICATION_O,
  output logic                      LANDSCAPE_INDICATION_O,
  output logic                      ORIENT_SIGN_O,
  output logic                      TAP_INT_O,
  output logic                      IRQ_O,
  output logic                      MEAS_PWR_EN_O
);
  localparam int WARM_W = $clog2(TURN_ON_CYC_P + 1);

  logic                 lp_sel;
  logic                 chain_rst;
  logic                 ready_q;
  logic [WARM_W-1:0]    warm_cnt;
  logic                 ready_ev;
  logic                 sample_en;
  logic [1:0]           ctrl;
  logic [SW-1:0]        orient_thr;
  logic [CW-1:0]        stable_lim;
  logic [CW-1:0]        stab_eff;
  logic [SW-1:0]        tap_thr;
  logic [CW-1:0]        tap_lat;
  logic [CW-1:0]        tap_win;
  logic [IW-1:0]        irq_stat;
  logic [IW-1:0]        irq_en;
  logic [IW-1:0]        irq_clr;
  logic [IW-1:0]        next_irq_stat;
  logic [IW-1:0]        irq_ev;
  logic [DW-1:0]        next_rdata;
  logic signed [SW-1:0] acc [3];
  logic [2:0]           pos;
  logic [2:0]           neg;
  logic [2:0]           jerk;
  logic [2:0]           dom;
  ots_orient_t          next_cand;
  ots_orient_t          cand_q;
  ots_orient_t          orient_q;
  logic [CW-1:0]        run;
  logic                 orient_ev;
  logic                 orient_pos;
  logic                 is_port;
  logic                 is_land;

  ots_tap_if tap_if ();

  // power-down select and measurement chain power
  assign lp_sel        = LOW_POWER_SELECT_I;
  assign chain_rst     = SYS_RST_I || lp_sel;
  assign MEAS_PWR_EN_O = !lp_sel;

  // turn-on wait after power-down release
  always_ff @(posedge REF_CLK_I)
  begin
    if (chain_rst)
    begin
      warm_cnt <= '0;
      ready_q  <= 1'b0;
    end
    else if (!ready_q)
    begin
      if (warm_cnt == WARM_W'(TURN_ON_CYC_P - 1))
        ready_q <= 1'b1;
      else
        warm_cnt <= warm_cnt + WARM_W'(1);
    end
  end

  assign ready_ev  = !chain_rst && !ready_q && warm_cnt == WARM_W'(TURN_ON_CYC_P - 1);
  assign sample_en = SAMPLE_VALID_I && ready_q && !lp_sel;

  // per-axis classification
  assign acc[0] = ACC_X_I;
  assign acc[1] = ACC_Y_I;
  assign acc[2] = ACC_Z_I;

  generate
    for (genvar a = 0; a < 3; a++)
    begin : g_axis
      ots_axis_cls #(
        .W (SW)
      ) u_axis (
        .clk_i      (REF_CLK_I),
        .rst_i      (chain_rst),
        .smp_i      (sample_en),
        .val_i      (acc[a]),
        .lvl_thr_i  (orient_thr),
        .jerk_thr_i (tap_thr),
        .pos_o      (pos[a]),
        .neg_o      (neg[a]),
        .jerk_o     (jerk[a])
      );
    end
  endgenerate

  // candidate orientation from the single dominant axis
  assign dom = pos | neg;

  always_comb
  begin
    next_cand = OR_NONE;
    case (dom)
      3'b001: next_cand = pos[0] ? OR_LAND_RT : OR_LAND_LF;
      3'b010: next_cand = pos[1] ? OR_PORT_UP : OR_PORT_DN;
      3'b100: next_cand = pos[2] ? OR_FACE_UP : OR_FACE_DN;
      default: next_cand = OR_NONE;
    endcase
  end

  // steadiness run: same candidate, no jerk on any axis
  assign stab_eff = (stable_lim == '0) ? 8'h01 : stable_lim;

  always_ff @(posedge REF_CLK_I)
  begin
    if (chain_rst)
    begin
      cand_q <= OR_NONE;
      run    <= '0;
    end
    else if (sample_en)
    begin
      cand_q <= next_cand;
      if (next_cand == OR_NONE || |jerk)
        run <= '0;
      else if (next_cand != cand_q)
        run <= 8'h01;
      else if (run != 8'hff)
        run <= run + 8'h01;
    end
  end

  assign orient_ev = !chain_rst && run >= stab_eff && cand_q != OR_NONE && cand_q != orient_q;

  always_ff @(posedge REF_CLK_I)
  begin
    if (chain_rst)
      orient_q <= OR_NONE;
    else if (run >= stab_eff && cand_q != OR_NONE)
      orient_q <= cand_q;
  end

  // orientation lines
  assign is_port    = orient_q == OR_PORT_UP || orient_q == OR_PORT_DN;
  assign is_land    = orient_q == OR_LAND_LF || orient_q == OR_LAND_RT;
  assign orient_pos = orient_q == OR_PORT_UP || orient_q == OR_LAND_RT || orient_q == OR_FACE_UP;

  always_ff @(posedge REF_CLK_I)
  begin
    if (chain_rst)
    begin
      PORTRAIT_INDICATION_O  <= 1'b0;
      LANDSCAPE_INDICATION_O <= 1'b0;
      ORIENT_SIGN_O          <= 1'b0;
    end
    else
    begin
      PORTRAIT_INDICATION_O  <= ready_q && is_port;
      LANDSCAPE_INDICATION_O <= ready_q && is_land;
      ORIENT_SIGN_O          <= ready_q && orient_pos;
    end
  end

  // tap detection
  assign tap_if.sample = sample_en;
  assign tap_if.hit    = |jerk;

  ots_tap_det u_tap (
    .clk_i       (REF_CLK_I),
    .rst_i       (chain_rst),
    .single_en_i (ctrl[CTRL_SINGLE]),
    .double_en_i (ctrl[CTRL_DOUBLE]),
    .lat_i       (tap_lat),
    .win_i       (tap_win),
    .tap         (tap_if)
  );

  // configuration registers
  always_ff @(posedge REF_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      ctrl       <= CTRL_RST;
      orient_thr <= ORIENT_THR_RST;
      stable_lim <= STABLE_RST;
      tap_thr    <= TAP_THR_RST;
      tap_lat    <= TAP_LAT_RST;
      tap_win    <= TAP_WIN_RST;
      irq_en     <= IRQ_EN_RST;
    end
    else if (REG_WR_I)
    begin
      unique case (REG_ADDR_I)
        OFS_CTRL:       ctrl       <= REG_WDATA_I[1:0];
        OFS_ORIENT_THR: orient_thr <= REG_WDATA_I[SW-1:0];
        OFS_STABLE:     stable_lim <= REG_WDATA_I[CW-1:0];
        OFS_TAP_THR:    tap_thr    <= REG_WDATA_I[SW-1:0];
        OFS_TAP_LAT:    tap_lat    <= REG_WDATA_I[CW-1:0];
        OFS_TAP_WIN:    tap_win    <= REG_WDATA_I[CW-1:0];
        OFS_IRQ_EN:     irq_en     <= REG_WDATA_I[IW-1:0];
        default:        ;
      endcase
    end
  end

  // sticky event status, set wins over clear
  assign irq_clr = (REG_WR_I && REG_ADDR_I == OFS_IRQ_CLR) ? REG_WDATA_I[IW-1:0] : '0;

  always_comb
  begin
    irq_ev             = '0;
    irq_ev[IRQ_ORIENT] = orient_ev;
    irq_ev[IRQ_SINGLE] = tap_if.single_ev;
    irq_ev[IRQ_DOUBLE] = tap_if.double_ev;
    irq_ev[IRQ_READY]  = ready_ev;
    next_irq_stat      = (irq_stat & ~irq_clr) | irq_ev;
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (SYS_RST_I)
      irq_stat <= '0;
    else
      irq_stat <= next_irq_stat;
  end

  assign IRQ_O     = |(irq_stat & irq_en);
  assign TAP_INT_O = irq_stat[IRQ_SINGLE] || irq_stat[IRQ_DOUBLE];

  // read data, valid only in the cycle after the strobe
  always_comb
  begin
    next_rdata = '0;
    case (REG_ADDR_I)
      OFS_CTRL:       next_rdata[1:0]    = ctrl;
      OFS_ORIENT_THR: next_rdata[SW-1:0] = orient_thr;
      OFS_STABLE:     next_rdata[CW-1:0] = stable_lim;
      OFS_TAP_THR:    next_rdata[SW-1:0] = tap_thr;
      OFS_TAP_LAT:    next_rdata[CW-1:0] = tap_lat;
      OFS_TAP_WIN:    next_rdata[CW-1:0] = tap_win;
      OFS_STATUS:     next_rdata[STAT_LP:0] = {lp_sel, ready_q, orient_q};
      OFS_IRQ_STAT:   next_rdata[IW-1:0] = irq_stat;
      OFS_IRQ_EN:     next_rdata[IW-1:0] = irq_en;
      default:        next_rdata = '0;
    endcase
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (SYS_RST_I)
      REG_RDATA_O <= '0;
    else
      REG_RDATA_O <= REG_RD_I ? next_rdata : '0;
  end

  // checks
  property p_portrait;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    ready_q && !lp_sel && (orient_q == OR_PORT_UP || orient_q == OR_PORT_DN)
      |=> PORTRAIT_INDICATION_O && !LANDSCAPE_INDICATION_O;
  endproperty
  a_portrait: assert property (p_portrait) else $error("portrait line not high");

  property p_landscape;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    ready_q && !lp_sel && (orient_q == OR_LAND_LF || orient_q == OR_LAND_RT)
      |=> LANDSCAPE_INDICATION_O && !PORTRAIT_INDICATION_O;
  endproperty
  a_landscape: assert property (p_landscape) else $error("landscape line not high");

  property p_face;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    (orient_q == OR_FACE_UP || orient_q == OR_FACE_DN) |=> !PORTRAIT_INDICATION_O && !LANDSCAPE_INDICATION_O;
  endproperty
  a_face: assert property (p_face) else $error("face orientation drove class line");

  property p_sign;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    ready_q && !lp_sel && orient_q != OR_NONE
      |=> ORIENT_SIGN_O == ($past(orient_q) inside {OR_PORT_UP, OR_LAND_RT, OR_FACE_UP});
  endproperty
  a_sign: assert property (p_sign) else $error("sign line wrong");

  property p_lp_off;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    LOW_POWER_SELECT_I |=> !PORTRAIT_INDICATION_O && !LANDSCAPE_INDICATION_O && !ORIENT_SIGN_O && !ready_q;
  endproperty
  a_lp_off: assert property (p_lp_off) else $error("outputs active in power-down");

  property p_chain_off;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    LOW_POWER_SELECT_I [*2] |-> orient_q == OR_NONE && !tap_if.single_ev && !tap_if.double_ev && !MEAS_PWR_EN_O;
  endproperty
  a_chain_off: assert property (p_chain_off) else $error("detection during power-down");

  property p_turn_on;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    $fell(LOW_POWER_SELECT_I) |-> !ready_q [*8];
  endproperty
  a_turn_on: assert property (p_turn_on) else $error("ready too soon after power-down");

  property p_ready_at;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    $rose(ready_q) |-> $past(warm_cnt) == WARM_W'(TURN_ON_CYC_P - 1) && irq_stat[IRQ_READY];
  endproperty
  a_ready_at: assert property (p_ready_at) else $error("turn-on count wrong");

  property p_stable;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I || lp_sel)
    $changed(orient_q) |-> $past(run) >= $past(stab_eff) && orient_q == $past(cand_q);
  endproperty
  a_stable: assert property (p_stable) else $error("orientation changed before steady");

  property p_single;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    tap_if.single_ev |-> ctrl[CTRL_SINGLE] ##1 TAP_INT_O && irq_stat[IRQ_SINGLE];
  endproperty
  a_single: assert property (p_single) else $error("single tap not signalled");

  property p_double;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    tap_if.double_ev |-> ctrl[CTRL_DOUBLE] ##1 TAP_INT_O && irq_stat[IRQ_DOUBLE];
  endproperty
  a_double: assert property (p_double) else $error("double tap not signalled");

  property p_tap_off;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    ctrl == 2'b00 |-> !tap_if.single_ev && !tap_if.double_ev;
  endproperty
  a_tap_off: assert property (p_tap_off) else $error("tap event while disabled");
endmodule

// ---- src/ots_pkg.sv ----
// ots_pkg: register map, reset values, timing and types of the orientation and tap output block
// assumes one 125 MHz clock and 12-bit signed samples from the measurement chain
package ots_pkg;
  localparam int unsigned CLK_HZ      = 125_000_000;
  localparam int unsigned TURN_ON_MS  = 30;
  localparam int unsigned TURN_ON_CYC = CLK_HZ / 1000 * TURN_ON_MS;

  localparam int AW = 8;
  localparam int DW = 32;
  localparam int SW = 12;
  localparam int CW = 8;

  localparam logic [AW-1:0] OFS_CTRL       = 8'h00;
  localparam logic [AW-1:0] OFS_ORIENT_THR = 8'h04;
  localparam logic [AW-1:0] OFS_STABLE     = 8'h08;
  localparam logic [AW-1:0] OFS_TAP_THR    = 8'h0c;
  localparam logic [AW-1:0] OFS_TAP_LAT    = 8'h10;
  localparam logic [AW-1:0] OFS_TAP_WIN    = 8'h14;
  localparam logic [AW-1:0] OFS_STATUS     = 8'h18;
  localparam logic [AW-1:0] OFS_IRQ_STAT   = 8'h1c;
  localparam logic [AW-1:0] OFS_IRQ_CLR    = 8'h20;
  localparam logic [AW-1:0] OFS_IRQ_EN     = 8'h24;

  localparam int CTRL_SINGLE = 0;
  localparam int CTRL_DOUBLE = 1;
  localparam int STAT_READY  = 3;
  localparam int STAT_LP     = 4;
  localparam int IRQ_ORIENT  = 0;
  localparam int IRQ_SINGLE  = 1;
  localparam int IRQ_DOUBLE  = 2;
  localparam int IRQ_READY   = 3;
  localparam int IW          = 4;

  localparam logic [1:0]    CTRL_RST       = 2'h0;
  localparam logic [SW-1:0] ORIENT_THR_RST = 12'h200;
  localparam logic [CW-1:0] STABLE_RST     = 8'h10;
  localparam logic [SW-1:0] TAP_THR_RST    = 12'h400;
  localparam logic [CW-1:0] TAP_LAT_RST    = 8'h04;
  localparam logic [CW-1:0] TAP_WIN_RST    = 8'h20;
  localparam logic [IW-1:0] IRQ_EN_RST     = 4'h0;

  typedef enum logic [2:0] {
    OR_NONE    = 3'b000,
    OR_PORT_UP = 3'b001,
    OR_PORT_DN = 3'b010,
    OR_LAND_LF = 3'b011,
    OR_LAND_RT = 3'b100,
    OR_FACE_UP = 3'b101,
    OR_FACE_DN = 3'b110
  } ots_orient_t;

  typedef enum logic [1:0] {
    TP_IDLE = 2'b00,
    TP_LAT  = 2'b01,
    TP_WIN  = 2'b10
  } ots_tap_state_t;
endpackage

// ---- src/ots_tap_if.sv ----
// ots_tap_if: tap hit and tap events between the top and the tap detector
// assumes both ends run on the same clock
`timescale 1ns/10ps
interface ots_tap_if;
  logic sample;
  logic hit;
  logic single_ev;
  logic double_ev;
  modport src (output sample, output hit, input single_ev, input double_ev);
  modport det (input sample, input hit, output single_ev, output double_ev);
endinterface

// ---- src/ots_axis_cls.sv ----
// ots_axis_cls: one axis, level against threshold and sample-to-sample jerk
// assumes smp_i is a one-cycle enable per sample
`timescale 1ns/10ps
module ots_axis_cls
  import ots_pkg::*;
#(
  parameter int W = SW
)
(
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                smp_i,
  input  wire logic signed [W-1:0] val_i,
  input  wire logic        [W-1:0] lvl_thr_i,
  input  wire logic        [W-1:0] jerk_thr_i,
  output logic                     pos_o,
  output logic                     neg_o,
  output logic                     jerk_o
);
  logic signed [W-1:0] prev;
  logic                primed;
  logic signed [W:0]   diff;
  logic        [W:0]   mag;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      prev   <= '0;
      primed <= 1'b0;
    end
    else if (smp_i)
    begin
      prev   <= val_i;
      primed <= 1'b1;
    end
  end

  assign diff   = $signed({val_i[W-1], val_i}) - $signed({prev[W-1], prev});
  assign mag    = diff[W] ? -diff : diff;
  assign pos_o  = $signed({val_i[W-1], val_i}) > $signed({1'b0, lvl_thr_i});
  assign neg_o  = $signed({val_i[W-1], val_i}) < -$signed({1'b0, lvl_thr_i});
  assign jerk_o = primed && (mag > {1'b0, jerk_thr_i});
endmodule

// ---- src/ots_tap_det.sv ----
// ots_tap_det: single and double tap recognition, counted in samples
// assumes hit is only meaningful together with sample
`timescale 1ns/10ps
module ots_tap_det
  import ots_pkg::*;
(
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          single_en_i,
  input  wire logic          double_en_i,
  input  wire logic [CW-1:0] lat_i,
  input  wire logic [CW-1:0] win_i,
  ots_tap_if.det             tap
);
  ots_tap_state_t state;
  logic [CW-1:0]  cnt;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= TP_IDLE;
      cnt   <= '0;
    end
    else if (tap.sample)
    begin
      unique case (state)
        TP_IDLE:
        begin
          cnt <= '0;
          if (tap.hit && double_en_i)
            state <= TP_LAT;
        end
        TP_LAT:
        begin
          if (cnt >= lat_i)
          begin
            state <= TP_WIN;
            cnt   <= '0;
          end
          else
            cnt <= cnt + 8'h01;
        end
        TP_WIN:
        begin
          if (tap.hit || cnt >= win_i)
            state <= TP_IDLE;
          else
            cnt <= cnt + 8'h01;
        end
        default: state <= TP_IDLE;
      endcase
    end
  end

  // single: at once without double, else when the window runs out
  assign tap.single_ev = tap.sample && single_en_i && ((state == TP_IDLE && tap.hit && !double_en_i) ||
                         (state == TP_WIN && !tap.hit && cnt >= win_i));
  assign tap.double_ev = tap.sample && double_en_i && state == TP_WIN && tap.hit;

  property p_double_win;
    @(posedge clk_i) disable iff (rst_i)
    tap.double_ev |-> state == TP_WIN && cnt <= win_i && $past(state) != TP_IDLE;
  endproperty
  a_double_win: assert property (p_double_win) else $error("double tap outside window");
endmodule

// ---- dv/ots_host_model.sv ----
// ots_host_model: host side, drives the power-down select and waits out the turn-on time
// assumes the bench asks for power-down through lp_req_i, changed right after a clock edge
`timescale 1ns/10ps
module ots_host_model
  import ots_pkg::*;
#(
  parameter int unsigned TON_P = 64
)
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic lp_req_i,
  output logic      low_power_select_o,
  output logic      lines_valid_o
);
  int unsigned wait_cnt;

  // low selects normal operation, high requests power-down
  assign low_power_select_o = lp_req_i;

  // lines are trusted only after the turn-on time
  always_ff @(posedge clk_i)
  begin
    if (rst_i || low_power_select_o)
    begin
      wait_cnt      <= 0;
      lines_valid_o <= 1'b0;
    end
    else if (wait_cnt < TON_P)
      wait_cnt <= wait_cnt + 1;
    else
      lines_valid_o <= 1'b1;
  end
endmodule

// ---- dv/orientation_tap_signal_outputs_bench.sv ----
// orientation_tap_signal_outputs_bench: self-checking bench of the orientation and tap outputs
// assumes ots_signal_top with a shortened turn-on count and the host model beside it
`timescale 1ns/10ps
module orientation_tap_signal_outputs_bench
  import ots_pkg::*;
;
  localparam int unsigned TON = 64;
  logic                 clk = 1'b0;
  logic                 rst = 1'b1;
  logic                 lp_req = 1'b0;
  logic                 lps;
  logic                 lines_valid;
  logic                 vld = 1'b0;
  logic signed [SW-1:0] ax = '0;
  logic signed [SW-1:0] ay = '0;
  logic signed [SW-1:0] az = '0;
  logic [AW-1:0]        addr = '0;
  logic [DW-1:0]        wdata = '0;
  logic                 wr_s = 1'b0;
  logic                 rd_s = 1'b0;
  logic [DW-1:0]        rdata;
  logic                 por;
  logic                 lan;
  logic                 sgn;
  logic                 tap_int;
  logic                 irq;
  logic                 pwr_en;
  logic [31:0]          seed = 32'h1e03;
  logic [31:0]          d;
  logic signed [SW-1:0] tv[3];
  int                   errors = 0;
  int                   checked = 0;
  int                   n;
  int                   lat;
  int                   win;
  logic [AW-1:0]        reg_ofs[10] = '{OFS_STATUS, OFS_CTRL, OFS_ORIENT_THR, OFS_STABLE, OFS_TAP_THR,
                                        OFS_TAP_LAT, OFS_TAP_WIN, OFS_IRQ_EN, OFS_IRQ_CLR, 8'h30};
  logic [31:0]          reg_rst[10] = '{32'h0, 32'(CTRL_RST), 32'(ORIENT_THR_RST), 32'(STABLE_RST),
                                        32'(TAP_THR_RST), 32'(TAP_LAT_RST), 32'(TAP_WIN_RST),
                                        32'(IRQ_EN_RST), 32'h0, 32'h0};

  always #4 clk = ~clk;

  ots_signal_top #(.TURN_ON_CYC_P(TON)) dut (
    .REF_CLK_I              (clk),
    .SYS_RST_I              (rst),
    .LOW_POWER_SELECT_I     (lps),
    .SAMPLE_VALID_I         (vld),
    .ACC_X_I                (ax),
    .ACC_Y_I                (ay),
    .ACC_Z_I                (az),
    .REG_ADDR_I             (addr),
    .REG_WDATA_I            (wdata),
    .REG_WR_I               (wr_s),
    .REG_RD_I               (rd_s),
    .REG_RDATA_O            (rdata),
    .PORTRAIT_INDICATION_O  (por),
    .LANDSCAPE_INDICATION_O (lan),
    .ORIENT_SIGN_O          (sgn),
    .TAP_INT_O              (tap_int),
    .IRQ_O                  (irq),
    .MEAS_PWR_EN_O          (pwr_en)
  );

  ots_host_model #(.TON_P(TON)) host (
    .clk_i              (clk),
    .rst_i              (rst),
    .lp_req_i           (lp_req),
    .low_power_select_o (lps),
    .lines_valid_o      (lines_valid)
  );

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // {code, portrait, landscape, sign} for axis a (0 x, 1 y, 2 z) and direction
  function automatic logic [5:0] orient_exp(input int a, input logic pos);
    ots_orient_t c;
    if (a == 1)
      c = pos ? OR_PORT_UP : OR_PORT_DN;
    else if (a == 0)
      c = pos ? OR_LAND_RT : OR_LAND_LF;
    else
      c = pos ? OR_FACE_UP : OR_FACE_DN;
    return {c, a == 1, a == 0, pos};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [31:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask

  task automatic rd(input logic [AW-1:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic smp(input logic signed [SW-1:0] x, input logic signed [SW-1:0] y, input logic signed [SW-1:0] z);
    @(posedge clk);
    ax  <= x;
    ay  <= y;
    az  <= z;
    vld <= 1'b1;
    @(posedge clk);
    vld <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic wait_ready(output int cyc);
    logic [31:0] s;
    cyc = 0;
    s   = '0;
    while (s[STAT_READY] !== 1'b1 && cyc < 400)
    begin
      rd(OFS_STATUS, s);
      cyc += 2;
    end
    chk(s[STAT_READY], 1'b1);
  endtask

  task automatic ochk(input int a, input logic pos);
    logic signed [SW-1:0] v[3];
    logic [5:0]           e;
    logic [31:0]          s;
    seed = xs(seed);
    v[0] = {{3{seed[8]}}, seed[8:0]};
    v[1] = {{3{seed[17]}}, seed[17:9]};
    v[2] = {{3{seed[26]}}, seed[26:18]};
    v[a] = 12'h201 + {3'h0, seed[31:23]};
    if (!pos)
      v[a] = -v[a];
    repeat (3) smp(v[0], v[1], v[2]);
    settle();
    e = orient_exp(a, pos);
    rd(OFS_STATUS, s);
    chk(s[2:0], e[5:3]);
    chk({por, lan, sgn}, e[2:0]);
    chk(lines_valid, 1'b1);
  endtask

  task automatic tapseq(input int q, input logic [31:0] exp);
    logic [31:0] s;
    repeat (10) smp(0, 0, 0);
    wr(OFS_IRQ_CLR, 32'hf);
    smp(12'h7ff, 0, 0);
    chk(tap_int, 1'b0);
    repeat (lat + 1 + q) smp(12'h7ff, 0, 0);
    repeat (11) smp(0, 0, 0);
    rd(OFS_IRQ_STAT, s);
    chk(s & 32'h6, exp);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    chk(32'h0, 32'h1);
    conclude();
  end

  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    foreach (reg_ofs[i])
    begin
      rd(reg_ofs[i], d);
      chk(d, reg_rst[i]);
    end
    wr(8'h30, 32'hffffffff);
    rd(8'h30, d);
    chk(d, 32'h0);
    wr(OFS_STABLE, 32'h1);
    rd(OFS_STABLE, d);
    chk(d, 32'h1);
    wr(OFS_TAP_THR, 32'h3ff);
    rd(OFS_TAP_THR, d);
    chk(d, 32'h3ff);
    wr(OFS_TAP_THR, 32'(TAP_THR_RST));
    wait_ready(n);
    rd(OFS_IRQ_STAT, d);
    chk(d[IRQ_READY], 1'b1);
    wr(OFS_IRQ_EN, 32'h8);
    settle();
    chk(irq, 1'b1);
    wr(OFS_IRQ_CLR, 32'h8);
    settle();
    chk(irq, 1'b0);
    $display("test registers and turn-on done");

    for (int k = 0; k < 6; k++)
      ochk(k / 2, k % 2 == 0);
    chk(tap_int, 1'b0);
    $display("test orientations done");

    wr(OFS_CTRL, 32'h1);
    for (int a = 0; a < 3; a++)
    begin
      seed = xs(seed);
      smp(0, 0, 0);
      wr(OFS_IRQ_CLR, 32'hf);
      tv    = '{default: '0};
      tv[a] = 12'h600 + {3'h0, seed[8:0]};
      if (seed[9])
        tv[a] = -tv[a];
      smp(tv[0], tv[1], tv[2]);
      chk(tap_int, 1'b1);
      wr(OFS_IRQ_CLR, 32'h2);
      settle();
      chk(tap_int, 1'b0);
    end
    smp(0, 0, 0);
    wr(OFS_IRQ_EN, 32'h2);
    settle();
    chk(irq, 1'b1);
    wr(OFS_IRQ_EN, 32'h0);
    settle();
    chk(irq, 1'b0);
    chk(tap_int, 1'b1);
    $display("test single tap done");

    seed = xs(seed);
    lat  = 1 + seed[0];
    win  = 2 + seed[2:1];
    wr(OFS_TAP_LAT, 32'(lat));
    wr(OFS_TAP_WIN, 32'(win));
    wr(OFS_CTRL, 32'h3);
    tapseq(win, 32'h4);
    tapseq(win + 1, 32'h2);
    wr(OFS_CTRL, 32'h2);
    tapseq(win + 1, 32'h0);
    $display("test double tap done");

    ochk(1, 1'b1);
    @(posedge clk);
    lp_req <= 1'b1;
    settle();
    chk(pwr_en, 1'b0);
    chk({por, lan, sgn}, 3'h0);
    repeat (3) smp(0, 12'h300, 0);
    rd(OFS_STATUS, d);
    chk(d, 32'h10);
    chk(lines_valid, 1'b0);
    @(posedge clk);
    lp_req <= 1'b0;
    wait_ready(n);
    chk(32'(n >= TON - 2 && n <= TON + 8), 32'h1);
    chk(pwr_en, 1'b1);
    ochk(1, 1'b0);
    $display("test power-down done");
    conclude();
  end
endmodule
